// ===== pkg/lbrc_pkg.sv
// package for the loop branch and rotation control block
package lbrc_pkg;
  // widths
  localparam int CNT_W   = 64;
  localparam int EC_W    = 6;
  localparam int RRB_W   = 7;
  localparam int NROT    = 48;                 // rotating predicates 16..63
  localparam int PRED_W  = 64;
  localparam int STAGE0  = 16;                 // stage_predicate_zero index
  // reset values
  localparam logic [CNT_W-1:0]  LC_RST  = 64'h0;
  localparam logic [EC_W-1:0]   EC_RST  = 6'h00;
  localparam logic [RRB_W-1:0]  RRB_RST = 7'h00;
  localparam logic [PRED_W-1:0] PR_RST  = 64'h0000_0000_0000_0001;
  // register map, word addressed by byte address
  localparam logic [7:0] A_CTRL   = 8'h00;     // write: command, read: status
  localparam logic [7:0] A_LC_LO  = 8'h04;
  localparam logic [7:0] A_LC_HI  = 8'h08;
  localparam logic [7:0] A_EC     = 8'h0c;
  localparam logic [7:0] A_PR_LO  = 8'h10;
  localparam logic [7:0] A_PR_HI  = 8'h14;
  localparam logic [7:0] A_RRB    = 8'h18;
  localparam logic [7:0] A_CMP    = 8'h1c;     // compare write port
  // command codes in ctrl[2:0]
  typedef enum logic [2:0] {
    CMD_NONE  = 3'b000,
    CMD_WTOP  = 3'b001,
    CMD_CTOP  = 3'b010,
    CMD_PRROT = 3'b011
  } lbrc_cmd_t;
  // outcome of one loop branch
  typedef struct packed {
    logic taken;
    logic rotate;
  } lbrc_br_t;
endpackage

// ===== rtl/lbrc_pred_file.sv
`timescale 1ns/100ps
// predicate file with rotation and whole-group load
module lbrc_pred_file #(
  parameter int W = 64
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         reset,
  // controls
  input  wire logic         rot,
  input  wire logic         grp_ld,
  input  wire logic [W-1:0] grp_val,
  input  wire logic         bit_wr,
  input  wire logic [5:0]   bit_idx,
  input  wire logic         bit_val,
  // state
  output logic      [W-1:0] pr
);
  logic [W-1:0] pr_ff;
  logic [W-1:0] nxt_pr;
  assign pr = pr_ff;

  // next predicate values
  always_comb begin
    nxt_pr = pr_ff;
    if (grp_ld) begin
      nxt_pr[W-1:lbrc_pkg::STAGE0] = grp_val[W-1:lbrc_pkg::STAGE0]; // RULE_06
    end else if (bit_wr) begin
      nxt_pr[bit_idx] = bit_val;
    end
    if (rot) begin
      // each rotating predicate moves up one place
      nxt_pr[W-1:lbrc_pkg::STAGE0+1] = nxt_pr[W-2:lbrc_pkg::STAGE0]; // RULE_03 RULE_04
      nxt_pr[lbrc_pkg::STAGE0] = 1'b0; // RULE_08
    end
    nxt_pr[0] = 1'b1; // p0 is always one
  end

  // register
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pr_ff <= lbrc_pkg::PR_RST;
    end else begin
      pr_ff <= nxt_pr;
    end
  end
endmodule

// ===== rtl/lbrc_top.sv
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/100ps
// loop branch, counter and rotation control with avalon slave
// What this block does
// RULE_01 - while branch with zero predicate loops back only if epilog_counter > 1, and always decrements it; the code leaves it unchanged when it is already 0.
// RULE_02 - on fall-through the epilog_counter still decrements and one last rotation happens; the code leaves it unchanged when it is already 0.
// RULE_03 - rotation moves stage_predicate_zero into stage_predicate_one, so an unwritten zero makes the while branch exit.
// RULE_04 - the exit rotation shifts every rotating predicate up, predicate 31 into 32.
// RULE_05 - each counted branch decrements iteration_counter while it is nonzero, prolog passes included; epilog passes leave it at 0.
// RULE_06 - a move to rotating_predicate_group loads all rotating predicates at once.
// RULE_07 - a conditional compare that is false or unqualified leaves its target unchanged.
// RULE_08 - the while branch never touches iteration_counter and clears stage_predicate_zero after rotating.
// RULE_09 - rotation is renaming by a rename base that decrements on each rotation.
// RULE_10 - while branch with predicate one loops back, rotates and keeps epilog_counter.
module lbrc_top (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // avalon-mm slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // branch outcome
  output logic             br_taken,
  output logic             br_valid
);
  localparam int CW = lbrc_pkg::CNT_W;
  localparam int EW = lbrc_pkg::EC_W;
  localparam int RW = lbrc_pkg::RRB_W;

  logic [CW-1:0] lc_ff, nxt_lc;
  logic [EW-1:0] ec_ff, nxt_ec;
  logic [RW-1:0] rrb_ff, nxt_rrb;
  logic [31:0]   rd_ff, nxt_rd;
  logic          ack_ff, nxt_ack;
  logic          tk_ff, nxt_tk;
  logic          bv_ff, nxt_bv;
  logic [63:0]   pr;
  logic          rot, grp_ld, bit_wr, bit_val;
  logic [5:0]    bit_idx;
  logic [63:0]   grp_val;
  logic [31:0]   wmask;
  lbrc_pkg::lbrc_br_t br;
  logic          wr_go, rd_go;
  logic [2:0]    cmd;
  logic [5:0]    qp_idx;

  // one wait state then acknowledge
  assign avs_waitrequest = ~ack_ff;
  assign wr_go = avs_write & ack_ff;
  // read data latched on the request edge so it stands while acknowledged
  assign rd_go = avs_read & ~ack_ff;
  assign avs_readdata = rd_ff;
  assign br_taken = tk_ff;
  assign br_valid = bv_ff;
  assign cmd = avs_writedata[2:0];
  assign qp_idx = avs_writedata[13:8];
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // branch decision for the command being written
  always_comb begin
    br = '0;
    if (wr_go && avs_address == lbrc_pkg::A_CTRL) begin
      if (cmd == lbrc_pkg::CMD_WTOP) begin
        br.rotate = 1'b1; // RULE_02
        if (pr[qp_idx]) begin
          br.taken = 1'b1; // RULE_10
        end else begin
          br.taken = (ec_ff > 6'h01); // RULE_01
        end
      end else if (cmd == lbrc_pkg::CMD_CTOP) begin
        br.rotate = 1'b1;
        br.taken = (lc_ff != '0) || (ec_ff > 6'h01);
      end
    end
  end

  // counters, rename base and bus answer
  always_comb begin
    nxt_lc  = lc_ff;
    nxt_ec  = ec_ff;
    nxt_rrb = rrb_ff;
    nxt_ack = (avs_read | avs_write) & ~ack_ff;
    nxt_rd  = rd_ff;
    nxt_tk  = tk_ff;
    nxt_bv  = 1'b0;
    grp_ld  = 1'b0;
    grp_val = '0;
    bit_wr  = 1'b0;
    bit_idx = '0;
    bit_val = 1'b0;
    if (br.rotate) begin
      nxt_rrb = rrb_ff - 7'h01; // RULE_09
      nxt_tk  = br.taken;
      nxt_bv  = 1'b1;
      if (cmd == lbrc_pkg::CMD_WTOP) begin
        // iteration_counter untouched here
        if (!pr[qp_idx] && ec_ff != '0) begin
          nxt_ec = ec_ff - 6'h01; // RULE_01 RULE_02 RULE_08
        end
      end else if (lc_ff != '0) begin
        nxt_lc = lc_ff - 64'h1; // RULE_05
      end else if (ec_ff != '0) begin
        nxt_ec = ec_ff - 6'h01; // RULE_02
      end
    end
    if (wr_go) begin
      if (avs_address == lbrc_pkg::A_CTRL) begin
        if (cmd == lbrc_pkg::CMD_PRROT) begin
          grp_ld  = 1'b1; // RULE_06
          grp_val = {32'h0000_0000, avs_writedata[31:16], 16'h0000};
        end
      end else if (avs_address == lbrc_pkg::A_LC_LO) begin
        nxt_lc[31:0] = (lc_ff[31:0] & ~wmask) | (avs_writedata & wmask);
      end else if (avs_address == lbrc_pkg::A_LC_HI) begin
        nxt_lc[63:32] = (lc_ff[63:32] & ~wmask) | (avs_writedata & wmask);
      end else if (avs_address == lbrc_pkg::A_EC) begin
        if (avs_byteenable[0]) begin
          nxt_ec = avs_writedata[EW-1:0];
        end
      end else if (avs_address == lbrc_pkg::A_PR_HI) begin
        grp_ld  = 1'b1;
        grp_val = {avs_writedata, pr[31:0]};
      end else if (avs_address == lbrc_pkg::A_CMP) begin
        // [5:0] target, [13:8] qualifier, [16] result
        if (pr[qp_idx] && avs_writedata[16]) begin
          bit_wr  = 1'b1; // RULE_07
          bit_idx = avs_writedata[5:0];
          bit_val = 1'b1;
        end
      end
    end
    if (rd_go) begin
      if (avs_address == lbrc_pkg::A_CTRL) begin
        nxt_rd = {30'h0, bv_ff, tk_ff};
      end else if (avs_address == lbrc_pkg::A_LC_LO) begin
        nxt_rd = lc_ff[31:0];
      end else if (avs_address == lbrc_pkg::A_LC_HI) begin
        nxt_rd = lc_ff[63:32];
      end else if (avs_address == lbrc_pkg::A_EC) begin
        nxt_rd = {26'h0, ec_ff};
      end else if (avs_address == lbrc_pkg::A_PR_LO) begin
        nxt_rd = pr[31:0];
      end else if (avs_address == lbrc_pkg::A_PR_HI) begin
        nxt_rd = pr[63:32];
      end else if (avs_address == lbrc_pkg::A_RRB) begin
        nxt_rd = {25'h0, rrb_ff};
      end else begin
        nxt_rd = 32'h0;
      end
    end
  end

  // register state
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      lc_ff  <= lbrc_pkg::LC_RST;
      ec_ff  <= lbrc_pkg::EC_RST;
      rrb_ff <= lbrc_pkg::RRB_RST;
      rd_ff  <= 32'h0;
      ack_ff <= 1'b0;
      tk_ff  <= 1'b0;
      bv_ff  <= 1'b0;
    end else begin
      lc_ff  <= nxt_lc;
      ec_ff  <= nxt_ec;
      rrb_ff <= nxt_rrb;
      rd_ff  <= nxt_rd;
      ack_ff <= nxt_ack;
      tk_ff  <= nxt_tk;
      bv_ff  <= nxt_bv;
    end
  end

  assign rot = br.rotate;

  // predicate storage
  lbrc_pred_file #(.W(lbrc_pkg::PRED_W)) u_pred (
    .ref_clk (ref_clk),
    .reset   (reset),
    .rot     (rot),
    .grp_ld  (grp_ld),
    .grp_val (grp_val),
    .bit_wr  (bit_wr),
    .bit_idx (bit_idx),
    .bit_val (bit_val),
    .pr      (pr)
  );
endmodule

// ===== bench/lbrc_top_monitor.sv
// assertion checker bound to the loop branch control block
`timescale 1ns/100ps
module lbrc_top_monitor (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset,
  // bus and branch outcome
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        br_taken,
  input wire logic        br_valid
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // loop branch command accepted at this edge
  logic br_cmd;
  assign br_cmd = avs_write && !avs_waitrequest && avs_address == 8'h00
                  && avs_writedata[2:0] inside {3'h1, 3'h2};
  // bus handshake
  property p_one_wait;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_one_wait: assert property (p_one_wait) else $error("ack missing");
  property p_ack_one;
    !avs_waitrequest |=> avs_waitrequest; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack too long");
  property p_ack_cause;
    !avs_waitrequest |-> avs_read || avs_write; endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
  property p_unmapped;
    avs_read && !avs_waitrequest && avs_address > 8'h1c |->
      avs_readdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped data");
  property p_rd_hold;
    $changed(avs_readdata) |-> $past(avs_read && avs_waitrequest); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  // branch outcome
  property p_br_valid;
    br_cmd |=> br_valid; endproperty
  a_br_valid: assert property (p_br_valid) else $error("no outcome");
  property p_valid_cause;
    br_valid |-> $past(br_cmd) ##1 !br_valid; endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("bad pulse");
  property p_taken_hold;
    $changed(br_taken) |-> br_valid; endproperty
  a_taken_hold: assert property (p_taken_hold) else $error("taken moved");
  c_loop: cover property (br_valid && br_taken);
  c_exit: cover property (br_valid && !br_taken);
  c_unmapped: cover property (avs_read && avs_address > 8'h1c);
endmodule

bind lbrc_top lbrc_top_monitor u_mon (.ref_clk(ref_clk), .reset(reset),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .br_taken(br_taken),
  .br_valid(br_valid));

// ===== bench/testbench.sv
// self-checking bench for the loop branch control block
`timescale 1ns/100ps
module testbench;
  // design ports
  logic        ref_clk = 1'h0;
  logic        reset = 1'h1;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'h0;
  logic        avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        br_taken;
  logic        br_valid;
  // bookkeeping
  int          fail_count = 0;
  int          check_count = 0;
  int          br_seen = 0;
  int          br_sent = 0;
  logic [31:0] exp_q [$];
  logic [31:0] lo;
  logic [31:0] hi;
  // accesses: {read, address, write data or expected read data}
  logic [40:0] seq [31] = '{
    41'h104_0000_0000, 41'h10c_0000_0000, 41'h118_0000_0000,
    41'h110_0000_0001, 41'h120_0000_0000,
    41'h000_0001_0003, 41'h110_0001_0001, 41'h114_0000_0000,
    41'h00c_0000_0002, 41'h000_0000_1001, 41'h10c_0000_0002,
    41'h100_0000_0001, 41'h110_0002_0001, 41'h118_0000_007f,
    41'h01c_0000_0011, 41'h01c_0001_0511, 41'h01c_0001_0014,
    41'h110_0012_0001,
    41'h000_0000_1001, 41'h100_0000_0001, 41'h10c_0000_0001,
    41'h110_0024_0001, 41'h000_0000_1101, 41'h100_0000_0000,
    41'h10c_0000_0000, 41'h110_0048_0001, 41'h118_0000_007d,
    41'h01c_0001_001f, 41'h000_0000_1001, 41'h114_0000_0001,
    41'h110_0090_0001};

  always #4 ref_clk = ~ref_clk;

  lbrc_top DUT (.ref_clk(ref_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .br_taken(br_taken), .br_valid(br_valid));

  // one bus access, held until waitrequest is seen low at an edge
  task automatic bus(input logic [40:0] op);
    @(posedge ref_clk);
    if (op[40]) exp_q.push_back(op[31:0]);
    if (!op[40] && op[39:32] == 8'h00 && op[2:0] inside {3'h1, 3'h2}) begin
      br_sent++;
    end
    avs_read      <= op[40];
    avs_write     <= ~op[40];
    avs_address   <= op[39:32];
    avs_writedata <= op[31:0];
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'h0);
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t read %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // watcher: read data and branch outcome compared while they stand
  always @(negedge ref_clk) begin
    if (br_valid === 1'h1) br_seen++;
    if (avs_read && avs_waitrequest === 1'h0) begin
      if (avs_address == 8'h00) begin
        chk({31'h0, br_taken}, {31'h0, exp_q[0][0]});
      end
      chk(avs_readdata, exp_q.pop_front());
    end
  end

  // watchdog against a hung handshake
  initial begin
    #20000;
    fail_count++;
    report_and_stop;
  end

  // main sequence
  initial begin
    lo = ($urandom(31) & 32'hff) | 32'h4;
    hi = $urandom;
    repeat (3) @(posedge ref_clk);
    reset <= 1'h0;
    foreach (seq[i]) begin
      if (i == 5) begin
        bus({1'h0, 8'h04, lo});
        bus({1'h0, 8'h08, hi});
        bus(41'h014_8000_0001);
      end
      bus(seq[i]);
    end
    bus({1'h1, 8'h04, lo});
    repeat (3) bus(41'h000_0000_0002);
    bus({1'h1, 8'h04, lo - 32'h3});
    bus({1'h1, 8'h08, hi});
    bus(41'h100_0000_0001);
    repeat (2) @(posedge ref_clk);
    chk(br_seen, br_sent);
    report_and_stop;
  end
endmodule
